// [hw/usb_endpoint_mode_count_regs.sv]
// Endpoint mode and byte counter registers, with control endpoint locking.
// Assumes a CPU strobe port and a serial engine on the same clock; the
// engine pulses its events for one cycle each.
//
// Chosen here: the address-and-strobe port.
module usb_endpoint_mode_count_regs
  import ep_regs_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire logic [7:0]        cpu_addr,
  input  wire logic [7:0]        cpu_wdata,
  input  wire logic              cpu_wr,
  input  wire logic              cpu_rd,
  output logic      [7:0]        cpu_rdata,
  input  wire logic              eng_token_start,
  input  wire logic              eng_setup_data_start,
  input  wire logic              eng_ack_start,
  input  wire eng_update_s       eng_upd,
  output logic [NUM_EP*8-1:0]    ep_mode,
  output logic [NUM_EP*8-1:0]    ep_count,
  output logic [NUM_EP-1:0]      ep_event,
  output logic [NUM_EP-1:1]      stall_in,
  output logic [NUM_EP-1:1]      stall_out,
  output logic                   fifo0_write_block
);

  // Reset is released through two flops; everything uses the copy.
  logic rst_meta_b;
  logic rst_sync_b;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  logic [7:0] mode  [NUM_EP];
  logic [7:0] count [NUM_EP];
  logic       mode0_lock;
  logic       count0_lock;
  logic       setup_forced;
  logic       txn_busy;

  // A mode accepts SETUP tokens when its SETUP column says accept.
  function automatic logic accepts_setup(input logic [3:0] m);
    case (m)
      4'h1, 4'h2, 4'h3, 4'h4, 4'h6, 4'hA, 4'hB, 4'hE, 4'hF: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  // Mode nibble after a transaction.
  function automatic logic [3:0] next_nibble(input logic [3:0] m,
                                             input token_e     t,
                                             input logic       acked);
    if (t == TOK_SETUP && accepts_setup(m)) begin
      return MODE_NAK_IO; // R23
    end else if (acked && m[3] && m[0]) begin
      return {m[3:1], 1'b0}; // R22
    end else begin
      return m;
    end
  endfunction

  // Shared decodes of the engine result.
  wire logic rx_token   = (eng_upd.token == TOK_OUT) ||
                          (eng_upd.token == TOK_SETUP);
  wire logic [5:0] rx_count = 6'(eng_upd.rx_bytes + CRC_BYTES); // R16
  wire logic mode0_rd   = cpu_rd && (cpu_addr == MODE_OFF[0]);
  wire logic count0_rd  = cpu_rd && (cpu_addr == COUNT_OFF[0]);
  // A read only unlocks once this transaction's update point has passed.
  wire logic rd_allowed = !txn_busy; // R20

  logic [NUM_EP-1:0] upd_hit;

  genvar i;
  generate
    for (i = 0; i < NUM_EP; i++) begin : g_ep
      wire logic mode_wr  = cpu_wr && (cpu_addr == MODE_OFF[i]);
      wire logic count_wr = cpu_wr && (cpu_addr == COUNT_OFF[i]);
      // Disabled endpoints ignore all engine updates.
      wire logic hit      = eng_upd.valid && (eng_upd.ep == 3'(i)) &&
                            (mode[i][3:0] != MODE_DISABLE); // R24
      wire logic mode_lk  = (i == 0) && mode0_lock; // R9
      wire logic count_lk = (i == 0) && count0_lock; // R19
      wire logic [3:0] nib = next_nibble(mode[i][3:0], eng_upd.token,
                                         eng_upd.acked);
      wire logic in_flag  = (i == 0) ? (mode[i][IN_BIT] ||
                            eng_upd.token == TOK_IN) : mode[i][IN_BIT];
      wire logic out_flag = (i == 0) ? (mode[i][OUT_BIT] ||
                            eng_upd.token == TOK_OUT) : mode[i][OUT_BIT];
      wire logic [6:0] upd_low = {in_flag, out_flag, // R2 R3
                                  mode[i][ACK_BIT] | eng_upd.acked, // R1
                                  nib};
      wire logic [7:0] upd_count = rx_token ?
                       {eng_upd.toggle, eng_upd.crc_ok, rx_count} // R17 R18
                       : count[i]; // R15
      assign upd_hit[i] = hit;

      // Mode bits 6:0: the engine beats the CPU, locked bits drop writes.
      always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          mode[i][6:0] <= REG_RESET[6:0];
        end else if (hit) begin
          mode[i][6:0] <= upd_low; // R21 R25
        end else if (mode_wr && !mode_lk) begin
          mode[i][6:0] <= cpu_wdata[6:0]; // R7
        end
      end

      // Bit 7 is the SETUP flag on endpoint 0 and STALL elsewhere.
      always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          mode[i][7] <= REG_RESET[7];
        end else if (i == 0) begin
          if (eng_setup_data_start || setup_forced) begin
            mode[i][7] <= 1'b1; // R5
          end else if (mode_wr) begin
            mode[i][7] <= 1'b0; // R4
          end
        end else if (mode_wr) begin
          mode[i][7] <= cpu_wdata[STALL_BIT];
        end
      end

      // Counter register.
      always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          count[i] <= REG_RESET;
        end else if (hit) begin
          count[i] <= upd_count; // R16
        end else if (count_wr && !count_lk) begin
          count[i] <= cpu_wdata; // R15 R19
        end
      end

      // Event pulse on an ACKed update or any OUT or SETUP update; bad CRC still raises it.
      always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          ep_event[i] <= 1'b0;
        end else begin
          ep_event[i] <= hit && (eng_upd.acked || rx_token); // R17 R21
        end
      end

      assign ep_mode[i*8 +: 8]  = mode[i];
      assign ep_count[i*8 +: 8] = count[i];

      if (i > 0) begin : g_stall
        // Stall responses follow the registered mode one cycle later.
        always_ff @(posedge ref_clk or negedge rst_sync_b) begin
          if (!rst_sync_b) begin
            stall_out[i] <= 1'b0;
            stall_in[i]  <= 1'b0;
          end else begin
            stall_out[i] <= mode[i][STALL_BIT] &&
                            (mode[i][3:0] == MODE_ACK_IN); // R13
            stall_in[i]  <= mode[i][STALL_BIT] &&
                            (mode[i][3:0] == MODE_ACK_OUT); // R13
          end
        end
      end
    end
  endgenerate

  // Force window of the SETUP flag and the open transaction marker.
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      setup_forced <= 1'b0;
      txn_busy     <= 1'b0;
    end else begin
      if (eng_setup_data_start) begin
        setup_forced <= 1'b1; // R5
      end else if (eng_ack_start) begin
        setup_forced <= 1'b0;
      end
      if (eng_token_start) begin
        txn_busy <= 1'b1;
      end else if (eng_upd.valid) begin
        txn_busy <= 1'b0;
      end
    end
  end

  // Control endpoint locks; a same-cycle update beats the unlocking read.
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      mode0_lock  <= 1'b0;
      count0_lock <= 1'b0;
    end else begin
      if (upd_hit[0]) begin
        mode0_lock <= 1'b1; // R7 R25
      end else if (mode0_rd && rd_allowed) begin
        mode0_lock <= 1'b0; // R8 R20
      end
      if (upd_hit[0] && rx_token) begin
        count0_lock <= 1'b1; // R19
      end else if (count0_rd && rd_allowed) begin
        count0_lock <= 1'b0; // R19 R20
      end
    end
  end

  // FIFO writes for endpoint 0 stay blocked while the SETUP flag is up.
  wire logic next_fifo_block = mode[0][SETUP_BIT] || eng_setup_data_start;
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      fifo0_write_block <= 1'b0;
    end else begin
      fifo0_write_block <= next_fifo_block; // R11
    end
  end

  // Read mux; unmapped addresses return zero.
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    for (int k = 0; k < NUM_EP; k++) begin
      if (cpu_addr == MODE_OFF[k]) begin
        next_rdata = mode[k];
      end
      if (cpu_addr == COUNT_OFF[k]) begin
        next_rdata = count[k];
      end
    end
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      cpu_rdata <= 8'h00;
    end else if (cpu_rd) begin
      cpu_rdata <= next_rdata;
    end else begin
      cpu_rdata <= 8'h00;
    end
  end

  // Checks on the behaviour above.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_sync_b);

  property p_ack_set;
    upd_hit[1] && eng_upd.acked |=> mode[1][ACK_BIT];
  endproperty
  a_ack_set: assert property (p_ack_set) // R1
    else $error("ACK flag not set after acked update");

  property p_out_flag;
    upd_hit[0] && eng_upd.token == TOK_OUT |=> mode[0][OUT_BIT];
  endproperty
  a_out_flag: assert property (p_out_flag) // R2
    else $error("OUT received flag not set");

  property p_in_flag;
    upd_hit[0] && eng_upd.token == TOK_IN |=> mode[0][IN_BIT];
  endproperty
  a_in_flag: assert property (p_in_flag) // R3
    else $error("IN received flag not set");

  property p_setup_clear;
    cpu_wr && cpu_addr == MODE_OFF[0] && !setup_forced &&
    !eng_setup_data_start |=> !mode[0][SETUP_BIT];
  endproperty
  a_setup_clear: assert property (p_setup_clear) // R4
    else $error("CPU write did not clear SETUP flag");

  property p_setup_hold;
    eng_setup_data_start ##1 (!eng_ack_start)[*3] |->
    mode[0][SETUP_BIT];
  endproperty
  a_setup_hold: assert property (p_setup_hold) // R5
    else $error("SETUP flag dropped inside forced window");

  property p_mode_lock;
    mode0_lock && !upd_hit[0] ##0 $stable(mode0_lock) |=>
    $stable(mode[0][6:0]) or $past(upd_hit[0]);
  endproperty
  a_mode_lock: assert property (p_mode_lock) // R7
    else $error("Locked control mode bits changed by CPU");

  property p_unlock;
    mode0_rd && !txn_busy && !upd_hit[0] |=> !mode0_lock;
  endproperty
  a_unlock: assert property (p_unlock) // R8
    else $error("Read did not unlock control mode register");

  property p_busy_keeps;
    mode0_lock && txn_busy && !eng_upd.valid |=> mode0_lock;
  endproperty
  a_busy_keeps: assert property (p_busy_keeps) // R20
    else $error("Read before update point unlocked register");

  property p_ep1_write;
    cpu_wr && cpu_addr == MODE_OFF[1] && !upd_hit[1] |=>
    mode[1] == $past(cpu_wdata);
  endproperty
  a_ep1_write: assert property (p_ep1_write) // R9
    else $error("Non-control mode write not taken");

  property p_fifo_block;
    mode[0][SETUP_BIT] |=> fifo0_write_block;
  endproperty
  a_fifo_block: assert property (p_fifo_block) // R11
    else $error("FIFO write not blocked during SETUP");

  property p_rx_count;
    upd_hit[1] && eng_upd.token == TOK_OUT |=>
    count[1][5:0] == $past(eng_upd.rx_bytes) + CRC_BYTES &&
    count[1][VALID_BIT] == $past(eng_upd.crc_ok);
  endproperty
  a_rx_count: assert property (p_rx_count) // R16
    else $error("Received count or data valid wrong");

  property p_nak_after_ack;
    upd_hit[1] && eng_upd.acked && mode[1][3:0] == MODE_ACK_OUT |=>
    mode[1][3:0] == 4'h8;
  endproperty
  a_nak_after_ack: assert property (p_nak_after_ack) // R22
    else $error("Ack Out did not fall to Nak Out");

  c_setup_txn: cover property (eng_setup_data_start ##[1:40] eng_ack_start);
  c_lock_read: cover property (mode0_lock ##1 mode0_rd ##1 !mode0_lock);
  c_stall: cover property (stall_in[1] || stall_out[1]);

endmodule // usb_endpoint_mode_count_regs

// [hw/ep_regs_pkg.sv]
// Constants, types and register map for the endpoint mode and count logic.
// Assumes one clock; engine signals come from logic on that same clock.
//
// What this block and its firmware do
// R1 - Set the ACK flag when an engine transaction to that endpoint ends ACKed.
// R2 - Set control OUT-received flag on an OUT token; firmware clears it.
// R3 - Set control IN-received flag on an IN token; firmware clears it.
// R4 - Only engine sets SETUP flag; a CPU write to it clears it except inside the forced window.
// R5 - Hold SETUP flag high from SETUP data start until ACK start.
// R6 - Firmware leaves SETUP flag alone while forced and until first read.
// R7 - Engine update locks control mode bits 6:0 against CPU writes.
// R8 - CPU read of the control mode register removes its lock.
// R9 - Only the control mode and count registers lock; others take every write not beaten by a same-cycle update.
// R10 - Firmware reads back every control register after writing it.
// R11 - While SETUP flag is set, CPU writes to control FIFO are blocked.
// R12 - Firmware writes zero to reserved bits 6:5 of non-control modes.
// R13 - STALL bit stalls OUT in ACK-IN mode and IN in ACK-OUT mode.
// R14 - Firmware keeps STALL low outside ACK-IN and ACK-OUT modes.
// R15 - IN byte count is loaded by firmware, 0 to 32, and sent.
// R16 - OUT or SETUP count becomes received bytes plus two.
// R17 - Data-valid follows CRC result; bad CRC still raises the event.
// R18 - Toggle 0 is DATA0, 1 is DATA1; copied in on OUT or SETUP.
// R19 - Control counter locks on SETUP or OUT update until CPU read.
// R20 - Reads unlock only after the current transaction's update point.
// R21 - Update point refreshes mode, and count on OUT/SETUP, raises event if ACKed or OUT/SETUP, and on endpoint 0 locks.
// R22 - After an ACK an acknowledging mode drops to its NAK mode.
// R23 - SETUP to an enabled setup-accepting mode forces mode NAK IN/OUT.
// R24 - Reset disables every endpoint; disabled stays so until firmware writes.
// R25 - Engine update beats a same-cycle CPU write and sets the lock.
package ep_regs_pkg;

  localparam int NUM_EP = 5;

  // Register byte offsets; index 0 is the control endpoint.
  localparam logic [4:0][7:0] MODE_OFF  = {8'h44, 8'h42, 8'h16, 8'h14, 8'h12};
  localparam logic [4:0][7:0] COUNT_OFF = {8'h43, 8'h41, 8'h15, 8'h13, 8'h11};

  // Field positions.
  localparam int ACK_BIT    = 4;
  localparam int OUT_BIT    = 5;
  localparam int IN_BIT     = 6;
  localparam int SETUP_BIT  = 7;
  localparam int STALL_BIT  = 7;
  localparam int VALID_BIT  = 6;
  localparam int TOGGLE_BIT = 7;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [5:0] CRC_BYTES = 6'h02;

  // Mode encodings.
  localparam logic [3:0] MODE_DISABLE = 4'h0;
  localparam logic [3:0] MODE_NAK_IO  = 4'h1;
  localparam logic [3:0] MODE_ACK_OUT = 4'h9;
  localparam logic [3:0] MODE_ACK_IN  = 4'hD;

  typedef enum logic [3:0] {
    TOK_NONE  = 4'b0001,
    TOK_SETUP = 4'b0010,
    TOK_IN    = 4'b0100,
    TOK_OUT   = 4'b1000
  } token_e;

  // One transaction result posted by the serial engine at the update point.
  typedef struct packed {
    logic       valid;
    logic [2:0] ep;
    token_e     token;
    logic       acked;
    logic       crc_ok;
    logic [5:0] rx_bytes;
    logic       toggle;
  } eng_update_s;

endpackage : ep_regs_pkg

// [verification/usb_serial_engine_model.sv]
// Behavioural serial engine that posts one transaction per go pulse.
// Assumes the block's clock and a bench that waits while busy is high.
module usb_serial_engine_model
  import ep_regs_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        go,
  input  wire logic [3:0]  gap,
  input  wire eng_update_s txn,
  output logic             busy,
  output logic             eng_token_start,
  output logic             eng_setup_data_start,
  output logic             eng_ack_start,
  output eng_update_s      eng_upd
);
  timeunit 1ns;
  timeprecision 1ps;

  // Quiet state at time zero.
  initial begin
    busy = 1'b0;
    eng_token_start = 1'b0;
    eng_setup_data_start = 1'b0;
    eng_ack_start = 1'b0;
    eng_upd = '0;
  end

  // Phases run token, data, handshake, update; gap stretches the data
  // phase. Idle fields show inverted values so nothing stale looks valid.
  always begin
    @(posedge ref_clk);
    if (go) begin
      busy <= 1'b1;
      eng_token_start <= 1'b1;
      @(posedge ref_clk);
      eng_token_start <= 1'b0;
      eng_setup_data_start <= (txn.token == TOK_SETUP);
      @(posedge ref_clk);
      eng_setup_data_start <= 1'b0;
      repeat (gap) @(posedge ref_clk);
      eng_ack_start <= txn.acked;
      @(posedge ref_clk);
      eng_ack_start <= 1'b0;
      eng_upd <= txn;
      @(posedge ref_clk);
      busy <= 1'b0;
      eng_upd <= '{1'b0, ~txn.ep, TOK_NONE, ~txn.acked, ~txn.crc_ok,
                   ~txn.rx_bytes, ~txn.toggle};
    end
  end
endmodule // usb_serial_engine_model

// [verification/usb_endpoint_mode_count_regs_tb_top.sv]
// Self-checking bench for the endpoint mode and count registers.
// Assumes the serial engine model drives the engine side of the block.
module usb_endpoint_mode_count_regs_tb_top
  import ep_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic                ref_clk = 1'b0;
  logic                rst_b = 1'b0;
  logic                cpu_wr = 1'b0;
  logic                cpu_rd = 1'b0;
  logic                go = 1'b0;
  logic                rd_seen = 1'b0;
  logic                busy, ets, esd, eas, fifo_blk;
  logic [7:0]          cpu_addr = 8'h00;
  logic [7:0]          cpu_wdata = 8'h00;
  logic [7:0]          cpu_rdata, v;
  logic [3:0]          gap = 4'h0;
  eng_update_s         txn = '0;
  eng_update_s         eng_upd;
  logic [NUM_EP*8-1:0] ep_mode, ep_count;
  logic [NUM_EP-1:0]   ep_event;
  logic [NUM_EP-1:1]   stall_in, stall_out;
  int                  fail_count = 0;
  int                  num_checks = 0;
  int                  cycles = 0;
  int                  ev0 = 0;
  logic [7:0]          exp_q[$];

  always #2.5 ref_clk = ~ref_clk;

  usb_endpoint_mode_count_regs i_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .cpu_addr(cpu_addr),
    .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_rdata(cpu_rdata), .eng_token_start(ets),
    .eng_setup_data_start(esd), .eng_ack_start(eas), .eng_upd(eng_upd),
    .ep_mode(ep_mode), .ep_count(ep_count), .ep_event(ep_event),
    .stall_in(stall_in), .stall_out(stall_out),
    .fifo0_write_block(fifo_blk));

  usb_serial_engine_model i_eng (
    .ref_clk(ref_clk), .go(go), .gap(gap), .txn(txn), .busy(busy),
    .eng_token_start(ets), .eng_setup_data_start(esd),
    .eng_ack_start(eas), .eng_upd(eng_upd));

  task automatic chk(input string what, input logic [7:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, d);
    @(posedge ref_clk);
    cpu_addr <= a;
    cpu_wdata <= d;
    cpu_wr <= 1'b1;
    @(posedge ref_clk);
    cpu_wr <= 1'b0;
  endtask

  // The expected value is queued; the monitor below makes the compare.
  task automatic rd(input logic [7:0] a, exp);
    exp_q.push_back(exp);
    @(posedge ref_clk);
    cpu_addr <= a;
    cpu_rd <= 1'b1;
    @(posedge ref_clk);
    cpu_rd <= 1'b0;
  endtask

  task automatic run(input logic [2:0] ep, input token_e tk,
                     input logic ack, crc, input logic [5:0] n,
                     input logic tg, input logic [3:0] g);
    int k;
    @(posedge ref_clk);
    txn <= '{1'b1, ep, tk, ack, crc, n, tg};
    gap <= g;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    @(posedge ref_clk);
    for (k = 0; k < 60 && busy !== 1'b0; k++) @(posedge ref_clk);
    if (k == 60) chk("engine done", 8'h00, 8'h01);
    repeat (2) @(posedge ref_clk);
  endtask

  // Read data stands only in the cycle after the read, so look mid-cycle.
  always @(posedge ref_clk) rd_seen <= cpu_rd;
  always @(negedge ref_clk) begin
    if (rd_seen) chk("read data", exp_q.pop_front(), cpu_rdata);
  end

  // Event pulses last one cycle, so they are counted as they stand.
  always @(negedge ref_clk) begin
    if (ep_event[0] === 1'b1) ev0++;
  end

  // A hang is cut short well beyond the few hundred cycles needed.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      end_sim();
    end
  end

  initial begin
    void'($urandom(32'h01f4));
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    for (int i = 0; i < NUM_EP; i++) begin
      rd(MODE_OFF[i], 8'h00);
      rd(COUNT_OFF[i], 8'h00);
    end
    rd(8'h20, 8'h00);
    // Control endpoint: SETUP with bad CRC, then lock and unlock.
    wr(MODE_OFF[0], 8'h01);
    rd(MODE_OFF[0], 8'h01);
    run(3'd0, TOK_SETUP, 1'b1, 1'b0, 6'd8, 1'b0, 4'd2);
    chk("fifo block", 8'h01, {7'h00, fifo_blk});
    wr(COUNT_OFF[0], 8'h05);
    rd(COUNT_OFF[0], 8'h0A);
    rd(MODE_OFF[0], 8'h91);
    wr(MODE_OFF[0], 8'h0F);
    rd(MODE_OFF[0], 8'h0F);
    chk("fifo block", 8'h00, {7'h00, fifo_blk});
    wr(COUNT_OFF[0], 8'h20);
    rd(COUNT_OFF[0], 8'h20);
    run(3'd0, TOK_IN, 1'b1, 1'b1, 6'd0, 1'b0, 4'd0);
    // A read inside an open transaction must leave the lock in place,
    // so the write that follows it is still dropped.
    fork
      run(3'd0, TOK_IN, 1'b0, 1'b1, 6'd0, 1'b0, 4'd9);
      begin
        repeat (4) @(posedge ref_clk);
        rd(MODE_OFF[0], 8'h5E);
        wr(MODE_OFF[0], 8'h00);
      end
    join
    wr(MODE_OFF[0], 8'h00);
    rd(MODE_OFF[0], 8'h5E);
    wr(MODE_OFF[0], 8'h00);
    rd(MODE_OFF[0], 8'h00);
    run(3'd0, TOK_OUT, 1'b1, 1'b1, 6'd4, 1'b1, 4'd9);
    rd(MODE_OFF[0], 8'h00);
    rd(COUNT_OFF[0], 8'h20);
    // Non-control endpoint: OUT with good CRC never locks.
    wr(MODE_OFF[1], 8'h09);
    run(3'd1, TOK_OUT, 1'b1, 1'b1, 6'd5, 1'b1, 4'd1);
    chk("ep1 mode", 8'h18, ep_mode[15:8]);
    chk("ep1 count", 8'hC7, ep_count[15:8]);
    wr(COUNT_OFF[1], 8'h03);
    wr(MODE_OFF[1], 8'h0D);
    rd(COUNT_OFF[1], 8'h03);
    rd(MODE_OFF[1], 8'h0D);
    // STALL only alongside an acknowledging mode.
    wr(MODE_OFF[2], 8'h89);
    wr(MODE_OFF[3], 8'h8D);
    repeat (3) @(posedge ref_clk);
    chk("stall", 8'h09, {4'h0, stall_in[2], stall_out[2], stall_in[3],
                         stall_out[3]});
    for (int i = 0; i < 8; i++) begin
      v = {2'($urandom), 6'($urandom % 33)};
      wr(COUNT_OFF[4], v);
      rd(COUNT_OFF[4], v);
    end
    wr(MODE_OFF[4], 8'h0D);
    rd(MODE_OFF[4], 8'h0D);
    repeat (4) @(posedge ref_clk);
    chk("ep0 events", 8'd2, 8'(ev0));
    end_sim();
  end
endmodule // usb_endpoint_mode_count_regs_tb_top
